// ---- design/eirq_top.sv ----
// external request pin detection, control registers and vector selection
//
// Function
// - while enabled, sample pin with clocked logic; edge or edge-and-level
// - while clocks stop, an unclocked path lets an enabled pin wake
// - pin acts as request input only while pin enable is one
// - software selects active polarity of edges and levels
// - mode bit selects edges only or edges plus sustained levels
// - event always sets flag; interrupt only when enable bit set
// - rising polarity offers pull-down instead of pull-up
// - pin level feeds branch-if-high and branch-if-low while enabled
// - reset vector highest priority, fetched from topmost address pair
// - vectors 26 to 31 unassigned, lowest priority, left to software
// - several pending when mask clears: highest priority served first
// - writing one to acknowledge clears flag; level mode holds it
// - polarity one means rising or high; zero falling or low
`timescale 1ns/1ps
`default_nettype none
module eirq_top
  import eirq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire eirq_pkg::eirq_bus_t bus_i,
  output logic [eirq_pkg::DATA_W-1:0] rdata_o,
  input wire logic pin_i,
  input wire logic stop_mode_i,
  input wire logic [eirq_pkg::VEC_N-1:0] src_pending_i,
  input wire logic global_mask_i,
  output logic pull_up_en_o,
  output logic pull_down_en_o,
  output logic branch_if_pin_high_o,
  output logic branch_if_pin_low_o,
  output logic wake_o,
  output logic pin_irq_req_o,
  output logic int_o,
  output eirq_pkg::eirq_vec_t vec_o
);
  import eirq_pkg::*;

  // pin synchroniser and edge history
  logic sync1_q, sync2_q, prev_q;
  logic sync1_d, sync2_d, prev_d;
  // configuration and flag
  eirq_ctrl_t ctrl_q, ctrl_d;
  logic flag_q, flag_d;
  logic [STAT_W-1:0] stat_q, stat_d, en_q, en_d;
  logic [DATA_W-1:0] rdata_d;
  logic bih_q, bih_d, bil_q, bil_d;
  eirq_vec_t vec_d;
  eirq_vec_t vec_sel;
  logic [VEC_N-1:0] pend;

  logic act_now, act_prev, edge_det, det, ack_wr;
  logic [STAT_W-1:0] ev;

  function automatic logic hit(input eirq_bus_t b, input logic [ADDR_W-1:0] o);
    hit = (b.addr == o);
  endfunction

  // both sync2_q and prev_q are read downstream of the first stage
  always_comb begin
    sync1_d = pin_i;
    sync2_d = sync1_q;
    prev_d = sync2_q;
  end

  // no reset: the chain keeps following the pin through reset, so an
  // enable written right after release cannot see a false edge
  always_ff @(posedge sys_clk) begin
    sync1_q <= sync1_d;
    sync2_q <= sync2_d;
    prev_q <= prev_d;
  end

  // polarity folds the pin onto an active-high view
  always_comb begin
    act_now = ctrl_q.pol ? sync2_q : ~sync2_q;
    act_prev = ctrl_q.pol ? prev_q : ~prev_q;
    edge_det = act_now & ~act_prev;
    // level sensing only in the edge-and-level mode
    det = ctrl_q.en &
      (edge_det | (ctrl_q.mode & act_now));
    ack_wr = bus_i.we & hit(bus_i, OFS_CTRL) & bus_i.wdata[B_ACK];
  end

  // stop path is combinational from the pin: no clock needed to wake
  always_comb begin
    wake_o = stop_mode_i & ctrl_q.en &
      (ctrl_q.pol ? pin_i : ~pin_i);
  end

  // pull resistors follow polarity while the pin function is on
  always_comb begin
    pull_up_en_o = ctrl_q.en & ctrl_q.pull & ~ctrl_q.pol;
    pull_down_en_o = ctrl_q.en & ctrl_q.pull & ctrl_q.pol;
  end

  // registers, flag and event status
  always_comb begin
    ctrl_d = ctrl_q;
    flag_d = flag_q;
    en_d = en_q;
    ev = '0;
    ev[S_EVENT] = det;
    ev[S_OVERRUN] = det & flag_q & edge_det;
    if (bus_i.we && hit(bus_i, OFS_CTRL)) begin
      ctrl_d.ie = bus_i.wdata[B_IE];
      ctrl_d.en = bus_i.wdata[B_PE];
      ctrl_d.mode = bus_i.wdata[B_MOD];
      ctrl_d.pol = bus_i.wdata[B_EDG];
      ctrl_d.pull = bus_i.wdata[B_PULL];
    end
    if (bus_i.we && hit(bus_i, OFS_EN)) begin
      en_d = bus_i.wdata[STAT_W-1:0];
    end
    // a detection in the same cycle as the acknowledge wins, so a
    // sustained level keeps the flag up
    if (ack_wr) begin
      flag_d = 1'b0;
    end
    if (det) begin
      flag_d = 1'b1;
    end
    stat_d = stat_q;
    if (bus_i.we && hit(bus_i, OFS_CLR)) begin
      stat_d = stat_q & ~bus_i.wdata[STAT_W-1:0];
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      flag_q <= 1'b0;
      stat_q <= STAT_RST;
      en_q <= EN_RST;
    end else begin
      ctrl_q <= ctrl_d;
      flag_q <= flag_d;
      stat_q <= stat_d;
      en_q <= en_d;
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = '0;
    if (bus_i.re) begin
      if (hit(bus_i, OFS_CTRL)) begin
        rdata_d[B_IE] = ctrl_q.ie;
        rdata_d[B_FLAG] = flag_q;
        rdata_d[B_PE] = ctrl_q.en;
        rdata_d[B_MOD] = ctrl_q.mode;
        rdata_d[B_EDG] = ctrl_q.pol;
        rdata_d[B_PULL] = ctrl_q.pull;
      end else if (hit(bus_i, OFS_STAT)) begin
        rdata_d[STAT_W-1:0] = stat_q;
      end else if (hit(bus_i, OFS_EN)) begin
        rdata_d[STAT_W-1:0] = en_q;
      end
    end
  end

  // branch inputs report the synchronised level only while enabled
  always_comb begin
    bih_d = ctrl_q.en & sync2_q;
    bil_d = ctrl_q.en & ~sync2_q;
  end

  // vector selection, pin request replaces slot two of the sources
  always_comb begin
    pin_irq_req_o = flag_q & ctrl_q.ie;
    pend = src_pending_i;
    pend[VEC_PIN] = pin_irq_req_o;
    int_o = |(stat_q & en_q);
  end

  eirq_vector_map u_map (
    .pending_i(pend),
    .global_mask_i(global_mask_i),
    .sel_o(vec_sel)
  );

  always_comb begin
    vec_d = vec_sel;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_o <= '0;
      bih_q <= 1'b0;
      bil_q <= 1'b0;
      vec_o <= '0;
    end else begin
      rdata_o <= rdata_d;
      bih_q <= bih_d;
      bil_q <= bil_d;
      vec_o <= vec_d;
    end
  end

  assign branch_if_pin_high_o = bih_q;
  assign branch_if_pin_low_o = bil_q;

  // checks
  property p_rise_edge;
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_q.en && ctrl_q.pol && !ctrl_q.mode && sync2_q && !prev_q)
      |=> flag_q;
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("edge lost");

  property p_disabled;
    @(posedge sys_clk) disable iff (!rst_n)
    (!ctrl_q.en && !flag_q) |=> !flag_q;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("flag set off");

  property p_fall_edge;
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_q.en && !ctrl_q.pol && !sync2_q && prev_q) |=> flag_q;
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("fall lost");

  property p_no_wrong_edge;
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_q.en && !ctrl_q.mode && !flag_q && !edge_det && !ack_wr)
      |=> !flag_q;
  endproperty
  a_no_wrong_edge: assert property (p_no_wrong_edge)
    else $error("spurious flag");

  property p_level_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_q.en && ctrl_q.mode && act_now) |=> flag_q;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level");

  property p_ack;
    @(posedge sys_clk) disable iff (!rst_n)
    (ack_wr && !det) |=> !flag_q;
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear");

  property p_req;
    @(posedge sys_clk) disable iff (!rst_n)
    (flag_q && !ctrl_q.ie) |=> !(vec_o.valid && vec_o.num == VEC_PIN);
  endproperty
  a_req: assert property (p_req) else $error("request gating");

  property p_pull;
    @(posedge sys_clk) disable iff (!rst_n)
    (ctrl_q.en && ctrl_q.pull && ctrl_q.pol) |-> pull_down_en_o
      && !pull_up_en_o;
  endproperty
  a_pull: assert property (p_pull) else $error("pull select");

  property p_branch;
    @(posedge sys_clk) disable iff (!rst_n)
    $past(ctrl_q.en) |-> branch_if_pin_high_o == $past(sync2_q)
      && branch_if_pin_low_o == !$past(sync2_q);
  endproperty
  a_branch: assert property (p_branch) else $error("branch level");

  property p_wake;
    @(posedge sys_clk) disable iff (!rst_n)
    (stop_mode_i && ctrl_q.en && (pin_i == ctrl_q.pol)) |-> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_reset_vec;
    @(posedge sys_clk) disable iff (!rst_n)
    pend[VEC_RESET] |=> vec_o.valid && vec_o.num == 5'h00
      && vec_o.addr == 16'hfffe;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vec");

  property p_user_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    (pend[25:0] == 26'h0) |=> !vec_o.valid;
  endproperty
  a_user_idle: assert property (p_user_idle) else $error("user vec");

  property p_pin_vec;
    @(posedge sys_clk) disable iff (!rst_n)
    (pin_irq_req_o && !global_mask_i && pend[1:0] == 2'h0)
      |=> vec_o.num == 5'h02 && vec_o.addr == 16'hfffa;
  endproperty
  a_pin_vec: assert property (p_pin_vec)
    else $error("pin vec");

  c_level_ack: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ctrl_q.mode && ack_wr && det);
  c_pin_served: cover property (@(posedge sys_clk) disable iff (!rst_n)
    vec_o.valid && vec_o.num == VEC_PIN);
  c_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) wake_o);
endmodule
`default_nettype wire

// ---- design/eirq_vector_map.sv ----
// fixed-priority vector selection over all interrupt sources
`timescale 1ns/1ps
`default_nettype none
module eirq_vector_map
  import eirq_pkg::*;
(
  input wire logic [VEC_N-1:0] pending_i,
  input wire logic global_mask_i,
  output eirq_pkg::eirq_vec_t sel_o
);
  logic [VEC_N-1:0] qual;

  // reset and software interrupt ignore the global mask; user slots
  // have no hardware source behind them and never request
  genvar g;
  generate
    for (g = 0; g < VEC_N; g++) begin : g_qual
      if (g >= VEC_USER_LO) begin : g_user
        assign qual[g] = 1'b0;
      end else if (g <= VEC_SWI) begin : g_nmi
        assign qual[g] = pending_i[g];
      end else begin : g_mask
        assign qual[g] = pending_i[g] & ~global_mask_i;
      end
    end
  endgenerate

  // lowest number wins: reset, then software, then the pin
  always_comb begin
    sel_o = '0;
    for (int i = VEC_N - 1; i >= 0; i--) begin
      if (qual[i]) begin
        sel_o.valid = 1'b1;
        sel_o.num = VEC_W'(i);
        sel_o.addr = vec_addr(VEC_W'(i));
      end
    end
  end
endmodule
`default_nettype wire

// ---- inc/eirq_pkg.sv ----
// constants and carrier types for the external request pin block
package eirq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VEC_N = 32;
  localparam int VEC_W = 5;
  localparam int STAT_W = 2;

  // register offsets (byte addresses, one aligned word each)
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CLR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EN = 8'h0c;

  // control register field positions
  localparam int B_ACK = 0;
  localparam int B_IE = 1;
  localparam int B_FLAG = 2;
  localparam int B_PE = 3;
  localparam int B_MOD = 4;
  localparam int B_EDG = 5;
  localparam int B_PULL = 6;

  // status / enable / clear bit positions
  localparam int S_EVENT = 0;
  localparam int S_OVERRUN = 1;

  // reset values
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] EN_RST = 2'h0;

  // vector map
  localparam logic [VEC_W-1:0] VEC_RESET = 5'h00;
  localparam logic [VEC_W-1:0] VEC_SWI = 5'h01;
  localparam logic [VEC_W-1:0] VEC_PIN = 5'h02;
  localparam logic [VEC_W-1:0] VEC_USER_LO = 5'h1a;
  localparam logic [VEC_W-1:0] VEC_USER_HI = 5'h1f;
  localparam logic [15:0] VEC_TOP_ADDR = 16'hfffe;
  localparam logic [15:0] VEC_USER_BASE = 16'hffc0;

  typedef struct packed {
    logic pull;
    logic pol;
    logic mode;
    logic en;
    logic ie;
  } eirq_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } eirq_bus_t;

  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] num;
    logic [15:0] addr;
  } eirq_vec_t;

  // vector address of the high byte: topmost pair for vector 0, downward
  function automatic logic [15:0] vec_addr(input logic [VEC_W-1:0] n);
    vec_addr = VEC_TOP_ADDR - {10'h000, n, 1'b0};
  endfunction
endpackage

// ---- test/eirq_pin_src.sv ----
// model of the external source that drives the request pin
`timescale 1ns/1ps
`default_nettype none
module eirq_pin_src (
  input wire logic sys_clk,
  input wire logic drive,
  input wire logic level,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  output logic pin
);
  logic wander_q = 1'b0;
  // an undriven, unpulled pin must not look like a held level
  always_ff @(posedge sys_clk) begin
    wander_q <= ~wander_q;
  end
  always_comb begin
    if (drive) begin
      pin = level;
    end else if (pull_down_en) begin
      pin = 1'b0;
    end else if (pull_up_en) begin
      pin = 1'b1;
    end else begin
      pin = wander_q;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the request pin block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eirq_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic pa;
    logic pb;
    logic fl;
  } eirq_row_t;
  typedef struct packed {
    logic [31:0] pend;
    logic msk;
    logic v;
    logic [4:0] n;
  } eirq_vrow_t;
  // ctrl: 08 enable, 10 level mode, 20 rising, 40 pull
  localparam eirq_row_t ROWS [8] = '{
    '{8'h68, 1'b0, 1'b1, 1'b1}, '{8'h68, 1'b1, 1'b0, 1'b0},
    '{8'h48, 1'b1, 1'b0, 1'b1}, '{8'h08, 1'b0, 1'b1, 1'b0},
    '{8'h60, 1'b0, 1'b1, 1'b0}, '{8'h38, 1'b1, 1'b1, 1'b1},
    '{8'h28, 1'b1, 1'b1, 1'b0}, '{8'h58, 1'b0, 1'b0, 1'b1}};
  localparam eirq_vrow_t VROWS [6] = '{
    '{32'h00000021, 1'b0, 1'b1, 5'h00}, '{32'h00000020, 1'b1, 1'b0, 5'h00},
    '{32'h00000022, 1'b1, 1'b1, 5'h01}, '{32'hfc000000, 1'b0, 1'b0, 5'h00},
    '{32'h01000008, 1'b0, 1'b1, 5'h03}, '{32'h00000004, 1'b0, 1'b0, 5'h00}};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  eirq_bus_t bus = '0;
  logic [31:0] rdata, got, pend = 32'h0;
  logic pin, stop = 1'b0, gmask = 1'b1, drive = 1'b1, level = 1'b0;
  logic pu, pd, bh, bl, wake, preq, intr;
  eirq_vec_t vec;
  int mismatches = 0;
  int checked = 0;
  eirq_row_t r;
  always #5 sys_clk = ~sys_clk;
  eirq_top i_eirq_top (.sys_clk(sys_clk), .rst_n(rst_n), .bus_i(bus),
    .rdata_o(rdata), .pin_i(pin), .stop_mode_i(stop), .src_pending_i(pend),
    .global_mask_i(gmask), .pull_up_en_o(pu), .pull_down_en_o(pd),
    .branch_if_pin_high_o(bh), .branch_if_pin_low_o(bl), .wake_o(wake),
    .pin_irq_req_o(preq), .int_o(intr), .vec_o(vec));
  eirq_pin_src i_eirq_pin_src (.sys_clk(sys_clk), .drive(drive),
    .level(level), .pull_up_en(pu), .pull_down_en(pd), .pin(pin));
  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge sys_clk);
    bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge sys_clk);
    bus.re <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_v(input logic v, input logic [4:0] n);
    eirq_vec_t e;
    e = {v, n, 16'hfffe - {10'h000, n, 1'b0}};
    checked++;
    if (v ? (vec !== e) : (vec.valid !== 1'b0)) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, vec, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk(20);
    rst_n <= 1'b1;
    #1 chk({vec, pu, pd, bh, bl, intr, preq, wake}, '0);
    chk(rdata, 32'h0);
    rd(OFS_CTRL, got);
    chk(got, 32'h0);
    rd(OFS_EN, got);
    chk(got, 32'h0);
    gmask <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = ROWS[i];
      level <= r.pa;
      wr(OFS_CTRL, {24'h0, r.ctrl | 8'h01});
      clk(6);
      wr(OFS_CTRL, {24'h0, r.ctrl | 8'h01});
      clk(2);
      level <= r.pb;
      clk(6);
      rd(OFS_CTRL, got);
      chk(got, {24'h0, r.ctrl | {r.fl, 2'h0}});
      got = {28'h0, r.ctrl[3] & r.ctrl[6] & ~r.ctrl[5],
        r.ctrl[3] & r.ctrl[6] & r.ctrl[5], r.ctrl[3] & r.pb,
        r.ctrl[3] & ~r.pb};
      chk({pu, pd, bh, bl}, got);
    end
    // released pin must settle to the pull that polarity selects
    drive <= 1'b0;
    wr(OFS_CTRL, 32'h69);
    clk(5);
    chk({bh, bl}, 2'b01);
    wr(OFS_CTRL, 32'h49);
    clk(5);
    chk({bh, bl}, 2'b10);
    drive <= 1'b1;
    level <= 1'b0;
    pend <= 32'h8;
    wr(OFS_EN, 32'h1);
    wr(OFS_CTRL, 32'h6b);
    wr(OFS_CLR, 32'h3);
    level <= 1'b1;
    clk(6);
    chk({intr, preq}, 2'b11);
    chk_v(1'b1, VEC_PIN);
    rd(OFS_STAT, got);
    chk(got, 32'h1);
    wr(OFS_EN, 32'h0);
    #1 chk(intr, 1'b0);
    wr(OFS_EN, 32'h1);
    #1 chk(intr, 1'b1);
    wr(OFS_CLR, 32'h1);
    #1 chk(intr, 1'b0);
    rd(OFS_CLR, got);
    chk(got, 32'h0);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, got);
    chk(got, 32'h0);
    wr(OFS_CTRL, 32'h69);
    level <= 1'b0;
    clk(3);
    level <= 1'b1;
    clk(6);
    chk(preq, 1'b0);
    rd(OFS_CTRL, got);
    chk(got, 32'h6c);
    // a second edge while the flag still stands counts as an overrun
    wr(OFS_CLR, 32'h3);
    level <= 1'b0;
    clk(3);
    level <= 1'b1;
    clk(6);
    rd(OFS_STAT, got);
    chk(got, 32'h3);
    wr(OFS_CTRL, 32'h01);
    for (int i = 0; i < 6; i++) begin
      pend <= VROWS[i].pend;
      gmask <= VROWS[i].msk;
      clk(3);
      chk_v(VROWS[i].v, VROWS[i].n);
    end
    wr(OFS_CTRL, 32'h08);
    stop <= 1'b1;
    level <= 1'b0;
    clk(1);
    #1 chk(wake, 1'b1);
    level <= 1'b1;
    clk(1);
    #1 chk(wake, 1'b0);
    // reset in mid-run must drop the flag and all configuration
    clk(1);
    rst_n <= 1'b0;
    stop <= 1'b0;
    clk(2);
    rst_n <= 1'b1;
    #1 chk({vec, pu, pd, bh, bl, intr, preq, wake}, '0);
    rd(OFS_CTRL, got);
    chk(got, 32'h0);
    rd(OFS_STAT, got);
    chk(got, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
